/* src/ee_pkg.sv */
// constants, states and carrier types shared by the two-wire memory slave
// assumes a 25 MHz system clock for the write-cycle time base
package ee_pkg;

    // memory geometry
    localparam int MEM_AW = 12;
    localparam int PAGE_AW = 5;
    localparam int PAGE_BYTES = 32;
    localparam int HI_AW = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // bit counter marks within one byte slot
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;

    // address byte fields
    localparam int DIR_POS = 0;
    localparam int SEL_LSB = 1;
    localparam int SEL_MSB = 3;
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 7;
    localparam logic [2:0] SEL_NONE = 3'h0;

    // internal write time and its cycle count at the system clock rate
    localparam int unsigned INTERNAL_WRITE_TIME_US = 5000;
    localparam int unsigned SYS_CLK_KHZ = 25000;
    localparam int unsigned INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_TIME_US * SYS_CLK_KHZ / 1000;
    localparam int WR_CNT_W = 17;

    typedef enum logic [2:0] {
        EE_IDLE    = 3'b000,
        EE_DEVADDR = 3'b001,
        EE_ADDR_HI = 3'b010,
        EE_ADDR_LO = 3'b011,
        EE_WDATA   = 3'b100,
        EE_RDATA   = 3'b101,
        EE_RACK    = 3'b110,
        EE_IGNORE  = 3'b111
    } ee_state_t;

    // one sample of the two bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } ee_line_t;

    // one sample of the static strap and protect pins
    typedef struct packed {
        logic wp;
        logic [2:0] sel;
    } ee_strap_t;

endpackage : ee_pkg

/* src/ee_i2c_slave.sv */
// two-wire serial memory slave: bus protocol, page buffer, memory array, write timer
// assumes scl/sda/straps are asynchronous pins; link_clk_i oversamples the bus lines
// and sys_clk_i is the free-running time base of the internal write cycle
//
// Functional notes
// - reset forces idle; release lands in standby waiting for start.
// - bus data sampled on scl rise, driven on scl fall.
// - sda only pulled low or released, never driven high.
// - unconnected strap pins read as low in the address compare.
// - sda falling with scl high is start; begins a transaction.
// - all traffic ignored without acknowledge until a start is seen.
// - sda rising with scl high is stop; ends any command.
// - address byte is four type bits, three select bits, direction bit.
// - respond only when select bits equal the strap levels.
// - direction bit one means read, zero means write.
// - strapless variant responds only to select bits all zero.
// - ninth clock is acknowledge: transmitter releases, receiver pulls low.
// - write is address byte, two address bytes, data, stop; all acknowledged.
// - stop after write starts one internal write; nothing acknowledged meanwhile.
// - up to 32 data bytes buffered within the latched page.
// - page offset increments per byte and wraps; later bytes overwrite.
// - protect pin sampled before first data byte; high refuses and abandons.
// - protect high blocks all writes; low lets writes proceed.
// - memory starts with every byte erased to all ones.
// - read acknowledges then shifts out current byte; standby after refusal, stop.
// - master acknowledge on a read byte fetches the next byte.
// - read address increments over whole memory and wraps to zero.
`timescale 1ns/1ps
module ee_i2c_slave #(
    parameter int unsigned WRITE_CYCLES = ee_pkg::INTERNAL_WRITE_CYCLES,
    parameter bit HAS_STRAPS = 1'b1,
    // device-type code: value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    // system clock domain
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // bus oversampling clock domain
    input wire logic link_clk_i,
    // two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // strap and protect pins
    input wire logic select_strap_bit0_i,
    input wire logic select_strap_bit1_i,
    input wire logic select_strap_bit2_i,
    input wire logic wp_i,
    // status
    output logic write_busy_o
);

    // sda drive: a zero bit pulls low, a one bit releases the line
    function automatic logic oe_n_for(input logic bit_val);
        oe_n_for = bit_val;
    endfunction : oe_n_for

    // ---------------- link domain: pin synchronisers ----------------
    ee_pkg::ee_line_t line_s1;
    ee_pkg::ee_line_t line_s2;
    ee_pkg::ee_line_t line_q;
    ee_pkg::ee_strap_t strap_s1;
    ee_pkg::ee_strap_t strap_s2;

    always_ff @(posedge link_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            line_s1 <= '1;
            line_s2 <= '1;
            line_q <= '1;
            strap_s1 <= '0;
            strap_s2 <= '0;
        end
        else
        begin
            line_s1 <= '{scl: scl_i, sda: sda_i};
            line_s2 <= line_s1;
            line_q <= line_s2;
            strap_s1 <= '{wp: wp_i,
                          sel: {select_strap_bit2_i, select_strap_bit1_i, select_strap_bit0_i}};
            strap_s2 <= strap_s1;
        end
    end

    // ---------------- link domain: bus events ----------------
    wire scl_rise = line_s2.scl & ~line_q.scl;
    wire scl_fall = ~line_s2.scl & line_q.scl;
    wire scl_high = line_s2.scl & line_q.scl;
    wire start_det = scl_high & line_q.sda & ~line_s2.sda;
    wire stop_det = scl_high & ~line_q.sda & line_s2.sda;

    // pulled-down pins arrive as low, so floating straps compare as zero
    wire [2:0] sel_bits = HAS_STRAPS ? strap_s2.sel : ee_pkg::SEL_NONE;
    wire wp_level = strap_s2.wp;

    // ---------------- link domain: state ----------------
    ee_pkg::ee_state_t state;
    logic [3:0] bit_cnt;
    logic ack_phase;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic [ee_pkg::MEM_AW-1:0] addr;
    logic [ee_pkg::HI_AW-1:0] addr_hi;
    logic wp_lat;
    logic [ee_pkg::PAGE_BYTES-1:0] page_valid;
    logic wr_req;
    logic commit_run;
    logic [ee_pkg::PAGE_AW-1:0] commit_idx;
    logic [ee_pkg::MEM_AW-1:ee_pkg::PAGE_AW] commit_base;
    logic ack_s1;
    logic ack_s2;
    // driven by the timer domain, read here only through ack_s1 and ack_s2
    logic ack_tgl;

    // erased at declaration so the array keeps a single driver
    logic [7:0] mem [0:(1 << ee_pkg::MEM_AW)-1] = '{default: ee_pkg::ERASED_BYTE};
    logic [7:0] page_buf [0:ee_pkg::PAGE_BYTES-1];

    // busy from stop until the timer answers and the page is committed
    wire wr_busy = (wr_req ^ ack_s2) | commit_run;

    wire byte_done = scl_fall & ~ack_phase & (bit_cnt == ee_pkg::BIT_LAST);
    wire [2:0] rx_sel = rx_byte[ee_pkg::SEL_MSB:ee_pkg::SEL_LSB];
    wire [3:0] rx_type = rx_byte[ee_pkg::TYPE_MSB:ee_pkg::TYPE_LSB];
    wire dev_match = (rx_type == DEV_TYPE) && (rx_sel == sel_bits);
    wire data_take = byte_done & (state == ee_pkg::EE_WDATA) & ~wp_lat;
    wire [ee_pkg::PAGE_AW-1:0] page_off = addr[ee_pkg::PAGE_AW-1:0];
    wire [7:0] mem_rd = mem[addr];
    wire launch = stop_det & (state == ee_pkg::EE_WDATA) & (|page_valid) & ~wr_busy;
    wire [ee_pkg::MEM_AW-1:0] commit_addr = {commit_base, commit_idx};

    always_ff @(posedge link_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end
        else
        begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // page buffer load, later bytes at the same offset overwrite
    always_ff @(posedge link_clk_i)
    begin
        if (data_take)
        begin
            page_buf[page_off] <= rx_byte;
        end
    end

    // one page entry per cycle moves into the array after the stop
    always_ff @(posedge link_clk_i)
    begin
        if (commit_run && page_valid[commit_idx])
        begin
            mem[commit_addr] <= page_buf[commit_idx];
        end
    end

    always_ff @(posedge link_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= ee_pkg::EE_IDLE;
            bit_cnt <= ee_pkg::BIT_FIRST;
            ack_phase <= 1'b0;
            rx_byte <= '0;
            tx_byte <= '0;
            addr <= '0;
            addr_hi <= '0;
            wp_lat <= 1'b0;
            page_valid <= '0;
            wr_req <= 1'b0;
            commit_run <= 1'b0;
            commit_idx <= '0;
            commit_base <= '0;
            sda_oe_n_o <= 1'b1;
            sda_o <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            if (commit_run)
            begin
                commit_idx <= commit_idx + 1'b1;
                if (&commit_idx)
                begin
                    commit_run <= 1'b0;
                    page_valid <= '0;
                end
            end
            if (start_det)
            begin
                state <= ee_pkg::EE_DEVADDR;
                bit_cnt <= ee_pkg::BIT_FIRST;
                ack_phase <= 1'b0;
                sda_oe_n_o <= 1'b1;
                if (!commit_run)
                begin
                    page_valid <= '0;
                end
            end
            else if (stop_det)
            begin
                state <= ee_pkg::EE_IDLE;
                ack_phase <= 1'b0;
                sda_oe_n_o <= 1'b1;
                if (launch)
                begin
                    wr_req <= ~wr_req;
                    commit_run <= 1'b1;
                    commit_idx <= '0;
                    commit_base <= addr[ee_pkg::MEM_AW-1:ee_pkg::PAGE_AW];
                end
            end
            else if (scl_rise && state != ee_pkg::EE_IDLE && state != ee_pkg::EE_IGNORE)
            begin
                if (state == ee_pkg::EE_RACK)
                begin
                    if (line_s2.sda)
                    begin
                        state <= ee_pkg::EE_IGNORE;
                    end
                end
                else if (!ack_phase)
                begin
                    rx_byte <= {rx_byte[6:0], line_s2.sda};
                    bit_cnt <= bit_cnt + ee_pkg::BIT_STEP;
                end
            end
            else if (scl_fall && state != ee_pkg::EE_IDLE && state != ee_pkg::EE_IGNORE)
            begin
                if (ack_phase)
                begin
                    // ninth clock over: release, or start the first read byte
                    ack_phase <= 1'b0;
                    bit_cnt <= ee_pkg::BIT_FIRST;
                    sda_oe_n_o <= 1'b1;
                    if (state == ee_pkg::EE_WDATA && !(|page_valid))
                    begin
                        wp_lat <= wp_level;
                    end
                    if (state == ee_pkg::EE_RDATA)
                    begin
                        sda_oe_n_o <= oe_n_for(mem_rd[7]);
                        tx_byte <= {mem_rd[6:0], 1'b0};
                    end
                end
                else if (state == ee_pkg::EE_RACK)
                begin
                    state <= ee_pkg::EE_RDATA;
                    bit_cnt <= ee_pkg::BIT_FIRST;
                    sda_oe_n_o <= oe_n_for(mem_rd[7]);
                    tx_byte <= {mem_rd[6:0], 1'b0};
                end
                else if (state == ee_pkg::EE_RDATA)
                begin
                    if (bit_cnt == ee_pkg::BIT_LAST)
                    begin
                        sda_oe_n_o <= 1'b1;
                        state <= ee_pkg::EE_RACK;
                        addr <= addr + 1'b1;
                    end
                    else
                    begin
                        sda_oe_n_o <= oe_n_for(tx_byte[7]);
                        tx_byte <= {tx_byte[6:0], 1'b0};
                    end
                end
                else if (byte_done)
                begin
                    unique case (state)
                        ee_pkg::EE_DEVADDR:
                        begin
                            if (dev_match && !wr_busy)
                            begin
                                ack_phase <= 1'b1;
                                sda_oe_n_o <= 1'b0;
                                state <= rx_byte[ee_pkg::DIR_POS] ? ee_pkg::EE_RDATA
                                                                   : ee_pkg::EE_ADDR_HI;
                            end
                            else
                            begin
                                state <= ee_pkg::EE_IGNORE;
                            end
                        end
                        ee_pkg::EE_ADDR_HI:
                        begin
                            addr_hi <= rx_byte[ee_pkg::HI_AW-1:0];
                            ack_phase <= 1'b1;
                            sda_oe_n_o <= 1'b0;
                            state <= ee_pkg::EE_ADDR_LO;
                        end
                        ee_pkg::EE_ADDR_LO:
                        begin
                            addr <= {addr_hi, rx_byte};
                            ack_phase <= 1'b1;
                            sda_oe_n_o <= 1'b0;
                            state <= ee_pkg::EE_WDATA;
                        end
                        ee_pkg::EE_WDATA:
                        begin
                            if (wp_lat)
                            begin
                                state <= ee_pkg::EE_IGNORE;
                                page_valid <= '0;
                            end
                            else
                            begin
                                ack_phase <= 1'b1;
                                sda_oe_n_o <= 1'b0;
                                page_valid[page_off] <= 1'b1;
                                addr[ee_pkg::PAGE_AW-1:0] <= page_off + 1'b1;
                            end
                        end
                        ee_pkg::EE_IDLE,
                        ee_pkg::EE_RDATA,
                        ee_pkg::EE_RACK,
                        ee_pkg::EE_IGNORE:
                        begin
                            state <= ee_pkg::EE_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    // ---------------- system domain: internal write timer ----------------
    logic req_s1;
    logic req_s2;
    logic req_q;
    logic [ee_pkg::WR_CNT_W-1:0] wr_cnt;

    wire req_event = req_s2 ^ req_q;
    wire [ee_pkg::WR_CNT_W-1:0] wr_load = ee_pkg::WR_CNT_W'(WRITE_CYCLES - 1);

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_q <= 1'b0;
            ack_tgl <= 1'b0;
            wr_cnt <= '0;
            write_busy_o <= 1'b0;
        end
        else
        begin
            req_s1 <= wr_req;
            req_s2 <= req_s1;
            req_q <= req_s2;
            if (req_event)
            begin
                wr_cnt <= wr_load;
                write_busy_o <= 1'b1;
            end
            else if (write_busy_o)
            begin
                if (wr_cnt == '0)
                begin
                    write_busy_o <= 1'b0;
                    ack_tgl <= ~ack_tgl;
                end
                else
                begin
                    wr_cnt <= wr_cnt - 1'b1;
                end
            end
        end
    end

endmodule : ee_i2c_slave

/* test/ee_i2c_slave_asserts.sv */
// concurrent checks on the pins of the two-wire memory slave
// assumes sda_i is the resolved wire and that the master idles with scl high
`timescale 1ns/1ps
module ee_i2c_slave_asserts #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    // clocks and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic link_clk_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    // straps, protect and status
    input wire logic select_strap_bit0_i,
    input wire logic select_strap_bit1_i,
    input wire logic select_strap_bit2_i,
    input wire logic wp_i,
    input wire logic write_busy_o
);
    logic scl_q;
    logic sda_q;
    logic in_frame;
    logic [16:0] busy_cnt;

    // start opens a frame, stop closes it, seen on the raw pins
    always_ff @(posedge link_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            in_frame <= 1'b0;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (scl_q && scl_i && sda_q && !sda_i)
                in_frame <= 1'b1;
            else if (scl_q && scl_i && !sda_q && sda_i)
                in_frame <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            busy_cnt <= 17'h0;
        else
            busy_cnt <= write_busy_o ? busy_cnt + 17'h1 : 17'h0;
    end

    sequence start_edge;
        scl_i && $fell(sda_i);
    endsequence
    sequence pulled_high;
        !sda_oe_n_o && scl_i;
    endsequence

    a_only_pulls_low: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        sda_o == 1'b0) else $error("sda driven high");
    a_drive_on_low: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        $changed(sda_oe_n_o) |-> !scl_i) else $error("sda changed while scl high");
    a_quiet_outside: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        !in_frame |-> sda_oe_n_o) else $error("sda pulled outside a frame");
    a_no_early_ack: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        start_edge |-> sda_oe_n_o[*8]) else $error("sda pulled right after start");
    a_ack_holds: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        pulled_high |=> !sda_oe_n_o || !scl_i) else $error("sda released while scl high");
    a_quiet_busy: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        write_busy_o |-> sda_oe_n_o) else $error("sda pulled during write cycle");
    a_busy_span: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(write_busy_o) |-> busy_cnt >= WRITE_CYCLES && busy_cnt <= WRITE_CYCLES + 2)
        else $error("write cycle length wrong");
    a_busy_after_stop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(write_busy_o) |-> scl_i && sda_i) else $error("write cycle without stop");
    a_busy_wp_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(write_busy_o) |-> !wp_i) else $error("write cycle while protected");
    a_reset_release: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(reset_n_i) |-> sda_oe_n_o && !write_busy_o) else $error("not idle after reset");
endmodule : ee_i2c_slave_asserts

bind ee_i2c_slave ee_i2c_slave_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_ee_i2c_slave_asserts (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .select_strap_bit0_i(select_strap_bit0_i), .select_strap_bit1_i(select_strap_bit1_i),
    .select_strap_bit2_i(select_strap_bit2_i), .wp_i(wp_i), .write_busy_o(write_busy_o));

/* test/ee_bus_master.sv */
// two-wire bus master model: owns scl and drives sda open-drain
// assumes sda_i is the resolved wire; every change lands on a clk_i rising edge
`timescale 1ns/1ps
module ee_bus_master #(
    parameter int HALF = 5
) (
    // time base
    input wire logic clk_i,
    // bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask : step

    // data moves only while scl is low; sampled late in the high phase
    task automatic bit_slot(input logic b, output logic s);
        scl_o <= 1'b0;
        step(1);
        sda_o <= b;
        step(HALF);
        scl_o <= 1'b1;
        step(HALF - 1);
        s = sda_i;
        step(1);
    endtask : bit_slot

    task automatic bstart();
        scl_o <= 1'b0;
        step(1);
        sda_o <= 1'b1;
        step(HALF);
        scl_o <= 1'b1;
        step(HALF);
        sda_o <= 1'b0;
        step(HALF);
    endtask : bstart

    task automatic bstop();
        scl_o <= 1'b0;
        step(1);
        sda_o <= 1'b0;
        step(HALF);
        scl_o <= 1'b1;
        step(HALF);
        sda_o <= 1'b1;
        step(HALF);
    endtask : bstop

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(d[i], s);
        bit_slot(1'b1, s);
        ack = !s;
    endtask : wbyte

    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, d[i]);
        bit_slot(!mack, s);
    endtask : rbyte
endmodule : ee_bus_master

/* test/testbench.sv */
// self-checking bench for the two-wire memory slave
// assumes ee_bus_master as the far side and a shortened write cycle
`timescale 1ns/1ps
module testbench;
    localparam int unsigned WR_CYC = 200;
    // device-type code: value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'h9;
    // type code of the strapless second part: value is arbitrary
    localparam logic [3:0] DEV_TYPE_B = 4'h3;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] strap = 3'h0;
    logic wp = 1'b0;
    logic m_scl;
    logic m_sda;
    logic sda_w;
    logic sda_o;
    logic sda_oe_n;
    logic busy;
    logic sda_o_b;
    logic sda_oe_n_b;
    logic busy_b;
    int mismatches = 0;
    int compares = 0;

    assign sda_w = m_sda & (sda_oe_n ? 1'b1 : sda_o) & (sda_oe_n_b ? 1'b1 : sda_o_b);
    always #20 sys_clk = ~sys_clk;
    initial
    begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    ee_i2c_slave #(.WRITE_CYCLES(WR_CYC), .HAS_STRAPS(1'b1), .DEV_TYPE(DEV_TYPE)) i_ee_i2c_slave (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .link_clk_i(link_clk),
        .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .select_strap_bit0_i(strap[0]), .select_strap_bit1_i(strap[1]),
        .select_strap_bit2_i(strap[2]), .wp_i(wp), .write_busy_o(busy));
    ee_bus_master #(.HALF(5)) i_ee_bus_master (
        .clk_i(sys_clk), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
    // strapless variant on the same bus, told apart by its type code
    ee_i2c_slave #(.WRITE_CYCLES(WR_CYC), .HAS_STRAPS(1'b0), .DEV_TYPE(DEV_TYPE_B))
        i_ee_i2c_slave_b (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .link_clk_i(link_clk),
        .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o_b), .sda_oe_n_o(sda_oe_n_b),
        .select_strap_bit0_i(strap[0]), .select_strap_bit1_i(strap[1]),
        .select_strap_bit2_i(strap[2]), .wp_i(wp), .write_busy_o(busy_b));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    function automatic logic [7:0] adr(input logic rd, input logic [2:0] sel);
        return {DEV_TYPE, sel, rd};
    endfunction : adr

    // upper nibble of the high address byte is set on purpose
    task automatic addr_set(input logic [11:0] a);
        logic ack;
        i_ee_bus_master.bstart();
        i_ee_bus_master.wbyte(adr(1'b0, strap), ack);
        chk("select ack", 8'h01, {7'h0, ack});
        i_ee_bus_master.wbyte({4'hF, a[11:8]}, ack);
        chk("high address ack", 8'h01, {7'h0, ack});
        i_ee_bus_master.wbyte(a[7:0], ack);
        chk("low address ack", 8'h01, {7'h0, ack});
    endtask : addr_set

    task automatic rd3(input logic [11:0] a, input logic [7:0] e0, e1, e2);
        logic ack;
        logic [7:0] d;
        addr_set(a);
        i_ee_bus_master.bstart();
        i_ee_bus_master.wbyte(adr(1'b1, strap), ack);
        chk("read select ack", 8'h01, {7'h0, ack});
        i_ee_bus_master.rbyte(1'b1, d);
        chk("read byte 0", e0, d);
        i_ee_bus_master.rbyte(1'b1, d);
        chk("read byte 1", e1, d);
        i_ee_bus_master.rbyte(1'b0, d);
        chk("read byte 2", e2, d);
        i_ee_bus_master.bstop();
    endtask : rd3

    task automatic t_idle();
        logic ack;
        chk("sda enable after reset", 8'h01, {7'h0, sda_oe_n});
        chk("busy after reset", 8'h00, {7'h0, busy});
        i_ee_bus_master.wbyte(adr(1'b0, strap), ack);
        chk("ack without start", 8'h00, {7'h0, ack});
        i_ee_bus_master.bstop();
    endtask : t_idle

    task automatic t_page();
        logic ack;
        int tries;
        addr_set(12'h01E);
        for (int i = 0; i < 34; i++)
        begin
            i_ee_bus_master.wbyte(8'h40 + i[7:0], ack);
            chk("data ack", 8'h01, {7'h0, ack});
        end
        i_ee_bus_master.bstop();
        repeat (8) @(posedge sys_clk);
        chk("busy after stop", 8'h01, {7'h0, busy});
        tries = 0;
        do
        begin
            tries++;
            i_ee_bus_master.bstart();
            i_ee_bus_master.wbyte(adr(1'b0, strap), ack);
            i_ee_bus_master.bstop();
        end
        while (!ack && tries < 40);
        chk("first poll refused", 8'h01, {7'h0, tries > 1});
        chk("poll finally acked", 8'h01, {7'h0, ack});
        rd3(12'hFFF, 8'hFF, 8'h42, 8'h43);
        rd3(12'h01D, 8'h5F, 8'h60, 8'h61);
        rd3(12'h01F, 8'h61, 8'hFF, 8'hFF);
    endtask : t_page

    task automatic t_wp();
        logic ack;
        wp <= 1'b1;
        addr_set(12'h100);
        i_ee_bus_master.wbyte(8'h00, ack);
        chk("protected data ack", 8'h00, {7'h0, ack});
        i_ee_bus_master.bstop();
        repeat (8) @(posedge sys_clk);
        chk("busy when protected", 8'h00, {7'h0, busy});
        wp <= 1'b0;
        rd3(12'h100, 8'hFF, 8'hFF, 8'hFF);
    endtask : t_wp

    task automatic t_select();
        logic ack;
        logic [7:0] d;
        strap <= 3'h5;
        @(posedge sys_clk);
        addr_set(12'h001);
        i_ee_bus_master.bstop();
        repeat (8) @(posedge sys_clk);
        chk("busy without data", 8'h00, {7'h0, busy});
        i_ee_bus_master.bstart();
        i_ee_bus_master.wbyte(adr(1'b1, 3'h2), ack);
        chk("foreign select ack", 8'h00, {7'h0, ack});
        i_ee_bus_master.bstart();
        i_ee_bus_master.wbyte(adr(1'b1, 3'h5), ack);
        chk("own select ack", 8'h01, {7'h0, ack});
        i_ee_bus_master.rbyte(1'b1, d);
        chk("immediate read", 8'h43, d);
        i_ee_bus_master.rbyte(1'b0, d);
        chk("sequential read", 8'h44, d);
        i_ee_bus_master.bstop();
    endtask : t_select

    // strapless part ignores its strap pins and answers only select 000
    task automatic t_strapless();
        logic ack;
        logic [7:0] d;
        i_ee_bus_master.bstart();
        i_ee_bus_master.wbyte({DEV_TYPE_B, strap, 1'b1}, ack);
        chk("strapless strap select ack", 8'h00, {7'h0, ack});
        i_ee_bus_master.bstart();
        i_ee_bus_master.wbyte({DEV_TYPE_B, 3'h0, 1'b1}, ack);
        chk("strapless zero select ack", 8'h01, {7'h0, ack});
        i_ee_bus_master.rbyte(1'b0, d);
        chk("strapless read", 8'hFF, d);
        i_ee_bus_master.bstop();
        chk("strapless busy", 8'h00, {7'h0, busy_b});
    endtask : t_strapless

    initial
    begin
        repeat (30000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_idle();
        t_page();
        t_wp();
        t_select();
        t_strapless();
        conclude();
    end
endmodule : testbench
